/* rtl/fsg_access_guard.sv */
// Flash section access guard: classifies self-programming, stalls the CPU,
// blocks reads and applies boot lock protection.
// Assumes the CPU gives one-cycle store/load requests and honours cpuStall.
`timescale 1ns/10ps
module fsg_access_guard
   import fsg_pkg::*;
#(
   parameter int ADDR_W      = 14,
   parameter int PROG_CYCLES = FSG_PROG_CYCLES
) (
   input  wire logic              core_clk,
   input  wire logic              resetn,
   // Register port
   input  wire logic [3:0]        regAddr,
   input  wire logic [7:0]        regWrData,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic      [7:0]        regRdData,
   // CPU side
   input  wire logic [ADDR_W-1:0] fetchAddr,
   input  wire logic              storeReq,
   input  wire logic              storeIsPage,
   input  wire logic [ADDR_W-1:0] zAddr,
   input  wire logic              loadReq,
   input  wire logic [ADDR_W-1:0] loadAddr,
   input  wire logic [7:0]        flashRdData,
   input  wire logic              vectorsInBoot,
   input  wire logic              chipErase,
   output logic                   cpuStall,
   output logic                   fetchBlocked,
   output logic                   irqMask,
   output logic      [7:0]        loadData,
   output logic                   loadValid,
   output logic                   loadRefused,
   output logic                   flashProgStart,
   output logic      [ADDR_W-1:0] flashProgAddr,
   output logic                   storeRefused
);
   // Limit writes shift by ADDR_W-5, so narrower flashes cannot be served
   if (ADDR_W < 5 || ADDR_W > 24) begin : gBadAddrW
      $error("ADDR_W out of range");
   end
   if (PROG_CYCLES < 1) begin : gBadProg
      $error("PROG_CYCLES must be positive");
   end

   localparam int CNT_W = $clog2(PROG_CYCLES + 1);

   fsg_state_e          state;
   fsg_state_e          next_state;
   logic [CNT_W-1:0]    progCount;
   logic                busyFlag;
   logic [ADDR_W-1:0]   haltStart;
   logic [ADDR_W-1:0]   bootStart;
   logic [1:0]          generalLock;
   logic [3:0]          lockBits;
   logic                lockStrobe;
   logic [3:0]          lockMask;
   logic                zHalting;
   logic                zBoot;
   logic                fHalting;
   logic                fBoot;
   logic                lHalting;
   logic                lBoot;
   logic                storeOk;
   logic                loadOk;
   logic                storeProtected;
   logic                loadProtected;
   logic                pageDone;
   logic                reenableWrite;

   fsg_section_decode #(.ADDR_W(ADDR_W)) uZDecode (
      .addr      (zAddr),
      .haltStart (haltStart),
      .bootStart (bootStart),
      .inHalting (zHalting),
      .inBoot    (zBoot)
   );

   fsg_section_decode #(.ADDR_W(ADDR_W)) uFetchDecode (
      .addr      (fetchAddr),
      .haltStart (haltStart),
      .bootStart (bootStart),
      .inHalting (fHalting),
      .inBoot    (fBoot)
   );

   fsg_section_decode #(.ADDR_W(ADDR_W)) uLoadDecode (
      .addr      (loadAddr),
      .haltStart (haltStart),
      .bootStart (bootStart),
      .inHalting (lHalting),
      .inBoot    (lBoot)
   );

   fsg_lock_bits uLocks (
      .core_clk      (core_clk),
      .resetn        (resetn),
      .programStrobe (lockStrobe),
      .programMask   (lockMask),
      .chipErase     (chipErase),
      .lockBits      (lockBits)
   );

   // Software lock programming through the lock register; writing a zero programs a bit
   always_comb begin
      lockStrobe = regWrite && (regAddr == FSG_REG_LOCK);
      lockMask   = ~regWrData[3:0];
   end

   // Protection decision; the general lock is deliberately not consulted
   always_comb begin
      storeProtected = zBoot ? fsg_store_refused(lockBits[FSG_LOCK_BOOT_HIGH:FSG_LOCK_BOOT_LOW])
                             : fsg_store_refused(lockBits[FSG_LOCK_APP_HIGH:FSG_LOCK_APP_LOW]);
      // R11 R12 R13 R14 R15 R17 R18
      loadProtected  = 1'b0;
      if (fBoot && !lBoot) begin
         loadProtected = fsg_load_refused(lockBits[FSG_LOCK_APP_HIGH:FSG_LOCK_APP_LOW]); // R14 R15
      end else if (!fBoot && lBoot) begin
         loadProtected = fsg_load_refused(lockBits[FSG_LOCK_BOOT_HIGH:FSG_LOCK_BOOT_LOW]); // R19
      end
      // Only boot code may start programming, and never while another page is busy
      storeOk = storeReq && fBoot && !storeProtected && (state == FSG_IDLE); // R21 R22
      // Concurrent-read section stays dark while busy
      // Nothing is readable while a halting page is programmed
      loadOk  = loadReq && (state != FSG_HALT) && !(busyFlag && !lHalting) // R02 R03
                && !loadProtected; // R22
   end

   // Page operation lifecycle, classified by the Z target page
   always_comb begin
      next_state = state;
      pageDone   = (progCount == CNT_W'(1));
      unique case (state)
         FSG_IDLE: begin
            if (storeOk && storeIsPage) begin
               next_state = zHalting ? FSG_HALT : FSG_CONCURR; // R04
            end
         end
         FSG_CONCURR: begin
            if (pageDone) begin
               next_state = FSG_IDLE; // R01
            end
         end
         FSG_HALT: begin
            if (pageDone) begin
               next_state = FSG_IDLE; // R02
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state <= FSG_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Programming timer
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         progCount <= '0;
      end else if (state == FSG_IDLE && next_state != FSG_IDLE) begin
         progCount <= CNT_W'(PROG_CYCLES);
      end else if (progCount != '0) begin
         progCount <= progCount - CNT_W'(1);
      end
   end

   // Busy flag: set by any page start, held after completion until software clears it
   always_comb begin
      reenableWrite = regWrite && (regAddr == FSG_REG_CTRL) && regWrData[FSG_CTRL_REENABLE_BIT]
                      && (state == FSG_IDLE);
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         busyFlag <= 1'b0;
      end else if (state == FSG_IDLE && next_state != FSG_IDLE) begin
         busyFlag <= 1'b1; // R05
      end else if (reenableWrite) begin
         busyFlag <= 1'b0; // R06
      end
   end

   // Section limits and general lock; general lock only reported, never gating
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         haltStart   <= ADDR_W'(1) << (ADDR_W - 2);
         bootStart   <= ADDR_W'(3) << (ADDR_W - 2);
         generalLock <= 2'h3;
      end else if (regWrite && regAddr == FSG_REG_CONFIG) begin
         generalLock <= regWrData[1:0]; // R11
         if (regWrData[7]) begin
            haltStart <= ADDR_W'(regWrData[6:2]) << (ADDR_W - 5);
         end else begin
            bootStart <= ADDR_W'(regWrData[6:2]) << (ADDR_W - 5);
         end
      end
   end

   // CPU stall and fetch blocking
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cpuStall     <= 1'b0;
         fetchBlocked <= 1'b0;
      end else begin
         cpuStall     <= (next_state == FSG_HALT); // R02
         // Halting fetches pass during concurrent programming
         fetchBlocked <= (next_state == FSG_HALT)
                         || ((busyFlag || next_state == FSG_CONCURR) && !fHalting); // R01 R03
      end
   end

   // Interrupt masking by section and vector placement
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irqMask <= 1'b0;
      end else begin
         irqMask <= (vectorsInBoot && !fBoot
                     && fsg_load_refused(lockBits[FSG_LOCK_APP_HIGH:FSG_LOCK_APP_LOW])) // R16
                 || (!vectorsInBoot && fBoot
                     && fsg_load_refused(lockBits[FSG_LOCK_BOOT_HIGH:FSG_LOCK_BOOT_LOW])); // R20
      end
   end

   // Load-program answer; refused loads return zero
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         loadData    <= 8'h00;
         loadValid   <= 1'b0;
         loadRefused <= 1'b0;
      end else begin
         loadValid   <= loadReq;
         loadRefused <= loadReq && !loadOk;
         loadData    <= loadOk ? flashRdData : 8'h00; // R22
      end
   end

   // Store-program hand-off to the flash engine
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         flashProgStart <= 1'b0;
         flashProgAddr  <= '0;
         storeRefused   <= 1'b0;
      end else begin
         flashProgStart <= storeOk; // R21
         storeRefused   <= storeReq && !storeOk; // R22
         if (storeOk) begin
            flashProgAddr <= zAddr; // R04
         end
      end
   end

   // Register read port, data in the cycle after the strobe
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         unique case (regAddr)
            FSG_REG_CTRL:   regRdData <= {1'b0, busyFlag, 5'h00, (state != FSG_IDLE)}; // R05
            FSG_REG_LOCK:   regRdData <= {4'h0, lockBits}; // R09
            FSG_REG_CONFIG: regRdData <= {6'h00, generalLock};
            FSG_REG_STATUS: regRdData <= {5'h00, state};
            default:        regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end
endmodule : fsg_access_guard

/* include/fsg_pkg.sv */
// Constants, states and helpers for the flash section access guard.
// Assumes a word-addressed program flash of ADDR_W bits behind a plain register port.
// Summary of operation
// (R01) Concurrent-read page program: CPU runs, halting section readable
// (R02) Halting-section page program: CPU stalled, nothing readable
// (R03) Concurrent-read section unreadable during any programming
// (R04) Classify by target page address, not fetch
// (R05) Busy flag reads one while section blocked
// (R06) Busy flag sticks until software clears it
// (R07) Software avoids concurrent-read section while programming
// (R08) Boot section lies wholly inside halting section
// (R09) Two independent lock pairs, four modes each
// (R10) Lock bits only programmed; chip erase unprograms
// (R11) General lock modes never gate load/store program
// (R12) App mode 1: no restrictions
// (R13) App mode 2: store refused, load allowed
// (R14) App mode 3: store refused, boot load refused
// (R15) App mode 4: boot load refused, store allowed
// (R16) App modes 3,4: mask interrupts in application
// (R17) Boot mode 1: no restrictions
// (R18) Boot modes 2,3: store into boot refused
// (R19) Boot modes 3,4: application load of boot refused
// (R20) Boot modes 3,4: mask interrupts in boot
// (R21) Store program honored only from boot code
// (R22) Refused store unchanged; refused load returns nothing
package fsg_pkg;
   // Register map, byte-free word offsets on the plain port
   localparam logic [3:0] FSG_REG_CTRL   = 4'h0; // Control/status: busy flag, operation active, busy clear
   localparam logic [3:0] FSG_REG_LOCK   = 4'h1; // Lock bits read-back and program
   localparam logic [3:0] FSG_REG_CONFIG = 4'h2; // Section limits and general lock
   localparam logic [3:0] FSG_REG_STATUS = 4'h3; // Live state
   // Control register fields
   localparam int FSG_CTRL_BUSY_BIT    = 6;
   localparam int FSG_CTRL_REENABLE_BIT = 4;
   localparam int FSG_CTRL_ERASE_BIT   = 0;
   // Lock field positions inside the lock register
   localparam int FSG_LOCK_APP_LOW  = 0;
   localparam int FSG_LOCK_APP_HIGH = 1;
   localparam int FSG_LOCK_BOOT_LOW = 2;
   localparam int FSG_LOCK_BOOT_HIGH = 3;
   // Reset values: all lock bits unprogrammed (one)
   localparam logic [3:0] FSG_LOCK_RESET = 4'hf;
   localparam logic [7:0] FSG_CTRL_RESET = 8'h00;
   // Erase/write time
   localparam int FSG_PROG_TIME_US = 4;
   localparam int FSG_CLK_MHZ      = 40;
   localparam int FSG_PROG_CYCLES  = FSG_PROG_TIME_US * FSG_CLK_MHZ;

   typedef enum logic [2:0] {
      FSG_IDLE    = 3'b001,
      FSG_CONCURR = 3'b010,
      FSG_HALT    = 3'b100
   } fsg_state_e;

   // Protection decode of one lock pair {high, low}
   function automatic logic fsg_store_refused(input logic [1:0] pair);
      fsg_store_refused = ~pair[0];          // Modes 2 and 3 have low bit programmed
   endfunction : fsg_store_refused

   function automatic logic fsg_load_refused(input logic [1:0] pair);
      fsg_load_refused = ~pair[1];           // Modes 3 and 4 have high bit programmed
   endfunction : fsg_load_refused
endpackage : fsg_pkg

/* rtl/fsg_lock_bits.sv */
// Boot lock bit store: bits only go from one to zero under software or
// programmer control; a chip erase returns them all to one.
// Assumes the programmer strobes come from logic on core_clk.
`timescale 1ns/10ps
module fsg_lock_bits
   import fsg_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic       programStrobe,
   input  wire logic [3:0] programMask,
   input  wire logic       chipErase,
   output logic      [3:0] lockBits
);
   // Programming clears bits only, so a lock cannot be loosened by software
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lockBits <= FSG_LOCK_RESET;
      end else if (chipErase) begin
         lockBits <= FSG_LOCK_RESET; // R10
      end else if (programStrobe) begin
         lockBits <= lockBits & ~programMask; // R10
      end
   end
endmodule : fsg_lock_bits

/* rtl/fsg_section_decode.sv */
// Combinational section classifier for one word address.
// Assumes boot start lies at or above the halting-section start.
`timescale 1ns/10ps
module fsg_section_decode
   import fsg_pkg::*;
#(
   parameter int ADDR_W = 14
) (
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [ADDR_W-1:0] haltStart,
   input  wire logic [ADDR_W-1:0] bootStart,
   output logic                   inHalting,
   output logic                   inBoot
);
   // Boot is clamped into the halting section so boot code stays fetchable
   always_comb begin
      inHalting = (addr >= haltStart);
      inBoot    = (addr >= bootStart) && inHalting; // R08
   end
endmodule : fsg_section_decode

/* sim/fsg_guard_chk.sv */
// Port checker for the access guard, bound to its top module.
// Assumes the default section limits stay in force for the whole run.
`timescale 1ns/10ps
module fsg_guard_chk
   import fsg_pkg::*;
#(
   parameter int ADDR_W      = 14,
   parameter int PROG_CYCLES = FSG_PROG_CYCLES
) (
   input wire logic              core_clk,
   input wire logic              resetn,
   input wire logic              storeReq,
   input wire logic              storeIsPage,
   input wire logic [ADDR_W-1:0] zAddr,
   input wire logic [ADDR_W-1:0] fetchAddr,
   input wire logic              loadReq,
   input wire logic [ADDR_W-1:0] loadAddr,
   input wire logic              cpuStall,
   input wire logic [7:0]        loadData,
   input wire logic              loadValid,
   input wire logic              loadRefused,
   input wire logic              flashProgStart,
   input wire logic [ADDR_W-1:0] flashProgAddr,
   input wire logic              storeRefused
);
   localparam logic [ADDR_W-1:0] HALT = ADDR_W'(1) << (ADDR_W-2);
   localparam logic [ADDR_W-1:0] BOOT = ADDR_W'(3) << (ADDR_W-2);
   logic pageReq;
   int   opLeft;
   // Page operation tracker; checks use only its middle so edge cycles never matter
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pageReq <= 1'b0;
         opLeft  <= 0;
      end else begin
         pageReq <= storeReq & storeIsPage;
         opLeft  <= (flashProgStart & pageReq) ? PROG_CYCLES : (opLeft > 0 ? opLeft - 1 : 0);
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_store_one_answer: assert property (storeReq |=> flashProgStart ^ storeRefused)
      else $error("store without a single answer");
   a_app_store_refused: assert property (storeReq && fetchAddr < BOOT |=> storeRefused && !flashProgStart)
      else $error("store from application code started programming");
   a_prog_addr_kept: assert property (storeReq ##1 flashProgStart |-> flashProgAddr == $past(zAddr))
      else $error("programming address differs from target");
   a_halt_stalls: assert property (flashProgStart && pageReq && flashProgAddr >= HALT |-> cpuStall[*4])
      else $error("halting page program did not stall");
   a_conc_runs: assert property (flashProgStart && pageReq && flashProgAddr < HALT |-> (!cpuStall)[*4])
      else $error("concurrent page program stalled the core");
   a_stall_ends: assert property ($rose(cpuStall) |-> ##[1:1000] !cpuStall)
      else $error("stall never ended");
   a_busy_blocks: assert property (loadReq && opLeft > 2 && loadAddr < HALT |=> loadRefused)
      else $error("concurrent section read during programming");
   a_load_answer: assert property (loadReq |=> loadValid || loadRefused)
      else $error("load without answer");
   a_refused_empty: assert property (loadRefused |-> loadData == 8'h00)
      else $error("refused load returned data");
   c_halt_prog: cover property (flashProgStart && pageReq && flashProgAddr >= HALT);
   c_load_refused: cover property (loadRefused);
   c_store_refused: cover property (storeRefused);
endmodule : fsg_guard_chk
bind fsg_access_guard fsg_guard_chk #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) chk_u (.*);

/* sim/fsg_cpu_model.sv */
// CPU core stand-in driving fetch, store and load requests into the guard.
// Assumes one task call at a time; a stalled core issues nothing.
`timescale 1ns/10ps
module fsg_cpu_model
   import fsg_pkg::*;
#(
   parameter int ADDR_W = 14
) (
   input  wire logic              core_clk,
   input  wire logic              cpuStall,
   output logic      [ADDR_W-1:0] fetchAddr,
   output logic                   storeReq,
   output logic                   storeIsPage,
   output logic      [ADDR_W-1:0] zAddr,
   output logic                   loadReq,
   output logic      [ADDR_W-1:0] loadAddr,
   output wire logic [7:0]        flashRdData,
   output logic                   vectorsInBoot
);
   logic [7:0] rdVal;
   logic [7:0] junk;
   // Array bytes are valid only beside a load; elsewhere they churn so stale data never matches
   assign flashRdData = loadReq ? rdVal : junk;
   initial begin
      fetchAddr = 14'h3400;
      storeReq = 1'b0;
      storeIsPage = 1'b0;
      zAddr = '0;
      loadReq = 1'b0;
      loadAddr = '0;
      vectorsInBoot = 1'b0;
      rdVal = 8'h00;
      junk = 8'h5a;
   end
   always @(posedge core_clk) junk <= ~junk;
   // Wait out any stall, then move the fetch point; programming code sits in boot
   task automatic start(input logic [ADDR_W-1:0] pc);
      int n;
      n = 0;
      @(posedge core_clk);
      while (cpuStall === 1'b1 && n < 1000) begin
         @(posedge core_clk);
         n++;
      end
      fetchAddr <= pc;
   endtask : start
   task automatic store(input logic [ADDR_W-1:0] pc, input logic [ADDR_W-1:0] z, input logic pg);
      start(pc);
      storeReq <= 1'b1;
      zAddr <= z;
      storeIsPage <= pg;
      @(posedge core_clk);
      storeReq <= 1'b0;
   endtask : store
   task automatic load(input logic [ADDR_W-1:0] pc, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      start(pc);
      loadReq <= 1'b1;
      loadAddr <= a;
      rdVal <= d;
      @(posedge core_clk);
      loadReq <= 1'b0;
   endtask : load
   task automatic setpc(input logic [ADDR_W-1:0] pc, input logic vib);
      start(pc);
      vectorsInBoot <= vib;
   endtask : setpc
endmodule : fsg_cpu_model

/* sim/flash_section_access_guard_test.sv */
// Self-checking bench: guard plus CPU stand-in, register port driven here.
// Assumes default limits: halting from 0x1000, boot from 0x3000.
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module flash_section_access_guard_test;
   import fsg_pkg::*;
   localparam int PC = 8;
   logic        core_clk, resetn, regWrite, regRead, chipErase, cpuStall, fetchBlocked, irqMask;
   logic        loadValid, loadRefused, flashProgStart, storeRefused, storeReq, storeIsPage;
   logic        loadReq, vectorsInBoot;
   logic [3:0]  regAddr;
   logic [7:0]  regWrData, regRdData, loadData, d;
   logic [13:0] fetchAddr, zAddr, loadAddr, flashProgAddr;
   wire  [7:0]  flashRdData;
   logic [31:0] seed = 32'h0001783d;
   int          n_fail, n_checks, n, lk, pi, vib, j, pc, z, a;
   fsg_access_guard #(.PROG_CYCLES(PC)) dut_u (.*);
   fsg_cpu_model cpu_u (.*);
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : xs
   // Reference decisions from the lock pairs {boot high, boot low, app high, app low}
   function automatic logic stRef(int lk, int pc, int z);
      return pc < 'h3000 || (z >= 'h3000 ? !lk[2] : !lk[0]);
   endfunction : stRef
   function automatic logic ldRef(int lk, int pc, int a);
      return (pc >= 'h3000 && a < 'h3000 && !lk[1]) || (pc < 'h3000 && a >= 'h3000 && !lk[3]);
   endfunction : ldRef
   function automatic logic irqRef(int lk, int pc, int vib);
      return (vib && pc < 'h3000 && !lk[1]) || (!vib && pc >= 'h3000 && !lk[3]);
   endfunction : irqRef
   task automatic wr(input logic [3:0] ad, input logic [7:0] v);
      @(posedge core_clk);
      regAddr <= ad;
      regWrData <= v;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] ad, output logic [7:0] v);
      @(posedge core_clk);
      regAddr <= ad;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 v = regRdData;
   endtask : rd
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Watchdog sized well past the expected run of about 600 cycles
   initial begin
      repeat (6000) @(posedge core_clk);
      n_fail++;
      close_out();
   end
   initial begin
      resetn = 1'b0;
      regAddr = 4'h0;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      chipErase = 1'b0;
      n_fail = 0;
      n_checks = 0;
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      rd(FSG_REG_CTRL, d); `CHK(d, FSG_CTRL_RESET)
      rd(FSG_REG_LOCK, d); `CHK(d, {4'h0, FSG_LOCK_RESET})
      rd(FSG_REG_STATUS, d); `CHK(d, 8'h01)
      rd(4'h9, d); `CHK(d, 8'h00)
      // Concurrent-read page: core runs, halting reads served, low section blocked
      cpu_u.store(14'h3400, 14'h0100, 1'b1); #1;
      `CHK({flashProgStart, flashProgAddr, cpuStall}, {1'b1, 14'h0100, 1'b0})
      d = xs(); cpu_u.load(14'h3400, 14'h1800, d); #1;
      `CHK({loadValid, loadRefused, loadData}, {2'b10, d})
      cpu_u.load(14'h3400, 14'h0200, xs()); #1;
      `CHK({loadRefused, loadData}, 9'h100)
      rd(FSG_REG_CTRL, d); `CHK(d, 8'h41)
      repeat (PC + 4) @(posedge core_clk);
      // Application fetches stay blocked until software clears the busy flag
      cpu_u.setpc(14'h0400, 1'b0);
      @(posedge core_clk);
      #1 `CHK(fetchBlocked, 1'b1)
      rd(FSG_REG_CTRL, d); `CHK(d, 8'h40)
      wr(FSG_REG_CTRL, 8'h10);
      rd(FSG_REG_CTRL, d); `CHK(d, 8'h00)
      `CHK(fetchBlocked, 1'b0)
      // Halting page: stall lasts exactly the programming time
      cpu_u.store(14'h3400, 14'h1100, 1'b1); #1;
      `CHK({cpuStall, fetchBlocked}, 2'b11)
      n = 0;
      while (cpuStall === 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1 n++;
      end
      `CHK(n, PC)
      wr(FSG_REG_CTRL, 8'h10);
      cpu_u.store(14'h0400, 14'h0800, 1'b0); #1;
      `CHK({flashProgStart, storeRefused}, 2'b01)
      // General lock to the strictest mode, boot limit rewritten unchanged
      wr(FSG_REG_CONFIG, 8'h60);
      rd(FSG_REG_CONFIG, d); `CHK(d, 8'h00)
      cpu_u.store(14'h3400, 14'h0800, 1'b0); #1;
      `CHK({flashProgStart, storeRefused}, 2'b10)
      // Every lock combination against store, load and interrupt masking
      for (lk = 0; lk < 16; lk++) begin
         @(posedge core_clk);
         chipErase <= 1'b1;
         @(posedge core_clk);
         chipErase <= 1'b0;
         wr(FSG_REG_LOCK, {4'h0, 4'(lk)});
         wr(FSG_REG_LOCK, 8'h0f);
         rd(FSG_REG_LOCK, d); `CHK(d, {4'h0, 4'(lk)})
         for (pi = 0; pi < 2; pi++) begin
            pc = pi ? 'h3400 : 'h0400;
            for (vib = 0; vib < 2; vib++) begin
               cpu_u.setpc(14'(pc), 1'(vib));
               @(posedge core_clk);
               #1 `CHK(irqMask, irqRef(lk, pc, vib))
            end
            for (j = 0; j < 2; j++) begin
               z = j ? 'h3100 : 'h0800;
               a = j ? 'h3800 : 'h2000;
               cpu_u.store(14'(pc), 14'(z), 1'b0); #1;
               `CHK({flashProgStart, storeRefused}, {!stRef(lk, pc, z), stRef(lk, pc, z)})
               d = xs(); cpu_u.load(14'(pc), 14'(a), d); #1;
               `CHK({loadRefused, loadData}, ldRef(lk, pc, a) ? 9'h100 : {1'b0, d})
            end
         end
      end
      close_out();
   end
endmodule : flash_section_access_guard_test
